//--- hw/acc3_top.v
`timescale 1ns/1ps
`include "acc3_regs.vh"
module acc3_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,

  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,

  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,

  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,

  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,

  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,

  // global dc filter enable for this channel
  input  wire        global_dc_filter_setting,

  // raw conversion results
  input  wire        sample_valid,
  input  wire [23:0] sample_data,

  // channel settings to the datapath
  output wire [9:0]  chan3_phase_delay,
  output wire        chan3_dc_filter_off,
  output reg         chan3_dc_filter_active,
  output wire [1:0]  chan3_input_select,
  output wire [23:0] chan3_offset_value,
  output wire [23:0] chan3_gain_value,

  // corrected conversion results
  output wire        result_valid,
  output wire [23:0] result_data
);

  // held write address and data
  reg         aw_held_reg;
  reg  [5:0]  aw_idx_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  // write decode
  wire        wr_fire;
  wire [15:0] lane_mask;
  wire        hit_cfg;
  wire        hit_ofs_up;
  wire        hit_ofs_lo;
  wire        hit_gain_up;
  wire        hit_gain_lo;
  wire        wr_mapped;

  // read decode
  wire        rd_fire;
  wire [5:0]  rd_idx;
  reg  [15:0] rd_value;
  reg         rd_mapped;

  // stored registers
  wire [15:0] cfg_q;
  wire [15:0] ofs_up_q;
  wire [15:0] ofs_lo_q;
  wire [15:0] gain_up_q;
  wire [15:0] gain_lo_q;

  // ---------------------------------------------------------------
  // write channel: address and data may arrive in either order
  // ---------------------------------------------------------------

  // ready drops once an item is held, which stalls a second write
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;

  // commit only once the previous response has been taken
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[7:2];
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // only the two low byte lanes reach the 16-bit registers
  assign lane_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  assign hit_cfg = (aw_idx_reg == `ACC3_IDX_CFG);
  assign hit_ofs_up = (aw_idx_reg == `ACC3_IDX_OFS_UP);
  assign hit_ofs_lo = (aw_idx_reg == `ACC3_IDX_OFS_LO);
  assign hit_gain_up = (aw_idx_reg == `ACC3_IDX_GAIN_UP);
  assign hit_gain_lo = (aw_idx_reg == `ACC3_IDX_GAIN_LO);
  assign wr_mapped = hit_cfg | hit_ofs_up | hit_ofs_lo | hit_gain_up | hit_gain_lo;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACC3_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `ACC3_RESP_OKAY : `ACC3_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------

  acc3_field_reg #(
    .RST_VAL (`ACC3_RST_CFG)
  ) u_cfg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && hit_cfg),
    .wr_mask (lane_mask & `ACC3_WMASK_CFG),
    .wr_data (w_data_reg[15:0]),
    .q_reg   (cfg_q)
  );

  acc3_field_reg #(
    .RST_VAL (`ACC3_RST_OFS_UP)
  ) u_ofs_up (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && hit_ofs_up),
    .wr_mask (lane_mask & `ACC3_WMASK_UP),
    .wr_data (w_data_reg[15:0]),
    .q_reg   (ofs_up_q)
  );

  acc3_field_reg #(
    .RST_VAL (`ACC3_RST_OFS_LO)
  ) u_ofs_lo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && hit_ofs_lo),
    .wr_mask (lane_mask & `ACC3_WMASK_LO),
    .wr_data (w_data_reg[15:0]),
    .q_reg   (ofs_lo_q)
  );

  acc3_field_reg #(
    .RST_VAL (`ACC3_RST_GAIN_UP)
  ) u_gain_up (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && hit_gain_up),
    .wr_mask (lane_mask & `ACC3_WMASK_UP),
    .wr_data (w_data_reg[15:0]),
    .q_reg   (gain_up_q)
  );

  acc3_field_reg #(
    .RST_VAL (`ACC3_RST_GAIN_LO)
  ) u_gain_lo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && hit_gain_lo),
    .wr_mask (lane_mask & `ACC3_WMASK_LO),
    .wr_data (w_data_reg[15:0]),
    .q_reg   (gain_lo_q)
  );

  // ---------------------------------------------------------------
  // read channel: one read in flight, answer one cycle after taking
  // ---------------------------------------------------------------

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[7:2];

  always @* begin
    rd_value = 16'h0000;
    rd_mapped = 1'b1;
    case (rd_idx)
      `ACC3_IDX_CFG: begin
        rd_value = cfg_q;
      end
      `ACC3_IDX_OFS_UP: begin
        rd_value = ofs_up_q;
      end
      `ACC3_IDX_OFS_LO: begin
        rd_value = ofs_lo_q;
      end
      `ACC3_IDX_GAIN_UP: begin
        rd_value = gain_up_q;
      end
      `ACC3_IDX_GAIN_LO: begin
        rd_value = gain_lo_q;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACC3_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      // upper half has no storage and reads zero
      s_axi_rdata <= {16'h0000, rd_value};
      s_axi_rresp <= rd_mapped ? `ACC3_RESP_OKAY : `ACC3_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // settings to the channel datapath
  // ---------------------------------------------------------------

  // phase delay is passed as raw two's complement
  assign chan3_phase_delay = cfg_q[`ACC3_PHASE_HI:`ACC3_PHASE_LO];
  assign chan3_dc_filter_off = cfg_q[`ACC3_DCOFF_BIT];
  assign chan3_input_select = cfg_q[`ACC3_MUX_HI:`ACC3_MUX_LO];

  // registered to keep the datapath enable glitch free
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan3_dc_filter_active <= 1'b0;
    end else begin
      chan3_dc_filter_active <= global_dc_filter_setting && !chan3_dc_filter_off;
    end
  end

  assign chan3_offset_value = {ofs_up_q, ofs_lo_q[15:8]};
  assign chan3_gain_value = {gain_up_q, gain_lo_q[15:8]};

  // ---------------------------------------------------------------
  // result correction
  // ---------------------------------------------------------------

  acc3_correct u_correct (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .sample_valid     (sample_valid),
    .sample_data      (sample_data),
    .offset_value     (chan3_offset_value),
    .gain_value       (chan3_gain_value),
    .result_valid_reg (result_valid),
    .result_data_reg  (result_data)
  );

endmodule // acc3_top

//--- hw/acc3_regs.vh
`ifndef ACC3_REGS_VH
`define ACC3_REGS_VH

// register indices; byte address is four times the index
`define ACC3_IDX_CFG       6'h18
`define ACC3_IDX_OFS_UP    6'h19
`define ACC3_IDX_OFS_LO    6'h1a
`define ACC3_IDX_GAIN_UP   6'h1b
`define ACC3_IDX_GAIN_LO   6'h1c

// reset values
`define ACC3_RST_CFG       16'h0000
`define ACC3_RST_OFS_UP    16'h0000
`define ACC3_RST_OFS_LO    16'h0000
`define ACC3_RST_GAIN_UP   16'h8000
`define ACC3_RST_GAIN_LO   16'h0000

// writable bits of each register
`define ACC3_WMASK_CFG     16'hffc7
`define ACC3_WMASK_UP      16'hffff
`define ACC3_WMASK_LO      16'hff00

// field positions in the config register
`define ACC3_PHASE_HI      15
`define ACC3_PHASE_LO      6
`define ACC3_DCOFF_BIT     2
`define ACC3_MUX_HI        1
`define ACC3_MUX_LO        0

// input select codes
`define ACC3_MUX_PINS      2'h0
`define ACC3_MUX_SHORT     2'h1
`define ACC3_MUX_POS_TEST  2'h2
`define ACC3_MUX_NEG_TEST  2'h3

// saturation limits of a 24-bit result
`define ACC3_SAT_MAX       24'h7f_ffff
`define ACC3_SAT_MIN       24'h80_0000

// bus responses
`define ACC3_RESP_OKAY     2'h0
`define ACC3_RESP_SLVERR   2'h2

`endif

//--- hw/acc3_field_reg.v
`timescale 1ns/1ps
module acc3_field_reg #(
  parameter [15:0] RST_VAL = 16'h0000
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write port
  input  wire        wr_en,
  input  wire [15:0] wr_mask,
  input  wire [15:0] wr_data,
  // stored value
  output reg  [15:0] q_reg
);

  // bits outside the mask never change, so reserved bits stay at reset zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= RST_VAL;
    end else if (wr_en) begin
      q_reg <= (q_reg & ~wr_mask) | (wr_data & wr_mask);
    end
  end

endmodule // acc3_field_reg

//--- hw/acc3_correct.v
`timescale 1ns/1ps
`include "acc3_regs.vh"
module acc3_correct (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // raw sample
  input  wire        sample_valid,
  input  wire [23:0] sample_data,
  // calibration
  input  wire [23:0] offset_value,
  input  wire [23:0] gain_value,
  // corrected sample
  output reg         result_valid_reg,
  output reg  [23:0] result_data_reg
);

  reg                diff_valid_reg;
  reg  signed [24:0] diff_reg;
  wire signed [24:0] diff_next;
  wire signed [25:0] gain_signed;
  wire signed [50:0] prod;
  wire signed [26:0] scaled;
  wire               overflow;

  // one guard bit so extreme offsets cannot wrap
  assign diff_next = $signed({sample_data[23], sample_data})
                   - $signed({offset_value[23], offset_value});
  assign gain_signed = $signed({2'b00, gain_value});
  assign prod = diff_reg * gain_signed;
  // drop 23 fraction bits of the gain
  assign scaled = prod[49:23];
  assign overflow = (scaled[26:23] != {4{scaled[23]}});

  always @(posedge aclk) begin
    if (!aresetn) begin
      diff_valid_reg <= 1'b0;
      diff_reg <= 25'h000_0000;
    end else begin
      diff_valid_reg <= sample_valid;
      if (sample_valid) begin
        diff_reg <= diff_next;
      end
    end
  end

  // saturate rather than wrap: gain near 2.0 can exceed full scale
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_valid_reg <= 1'b0;
      result_data_reg <= 24'h00_0000;
    end else begin
      result_valid_reg <= diff_valid_reg;
      if (diff_valid_reg) begin
        if (!overflow) begin
          result_data_reg <= scaled[23:0];
        end else if (scaled[26]) begin
          result_data_reg <= `ACC3_SAT_MIN;
        end else begin
          result_data_reg <= `ACC3_SAT_MAX;
        end
      end
    end
  end

endmodule // acc3_correct

//--- verif/acc3_props.sv
`timescale 1ns/1ps
`include "acc3_regs.vh"
module acc3_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  // settings and samples
  input wire        global_dc_filter_setting,
  input wire        sample_valid,
  input wire [9:0]  chan3_phase_delay,
  input wire        chan3_dc_filter_off,
  input wire        chan3_dc_filter_active,
  input wire [1:0]  chan3_input_select,
  input wire [23:0] chan3_offset_value,
  input wire [23:0] chan3_gain_value,
  input wire        result_valid
);
  // index of the read in flight, so rdata can be decoded
  reg [5:0] rd_idx;
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_idx <= s_axi_araddr[7:2];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_cfg;
    $past(!aresetn) |-> chan3_phase_delay == 10'h000 && !chan3_dc_filter_off
      && chan3_input_select == 2'h0;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("config not zero after reset");
  property p_rst_cal;
    $past(!aresetn) |-> chan3_gain_value == 24'h80_0000 && chan3_offset_value == 24'h00_0000;
  endproperty
  a_rst_cal: assert property (p_rst_cal) else $error("calibration reset wrong");
  property p_dc;
    $past(aresetn) |-> chan3_dc_filter_active
      == $past(global_dc_filter_setting && !chan3_dc_filter_off);
  endproperty
  a_dc: assert property (p_dc) else $error("dc filter enable wrong");
  property p_lat;
    sample_valid |-> ##2 result_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("result missing");
  property p_resp;
    s_axi_rvalid |-> s_axi_rresp == ((rd_idx >= `ACC3_IDX_CFG && rd_idx <= `ACC3_IDX_GAIN_LO)
      ? `ACC3_RESP_OKAY : `ACC3_RESP_SLVERR);
  endproperty
  a_resp: assert property (p_resp) else $error("read response wrong");
  property p_rsv;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
      && (rd_idx != `ACC3_IDX_CFG || s_axi_rdata[5:3] == 3'h0)
      && ((rd_idx != `ACC3_IDX_OFS_LO && rd_idx != `ACC3_IDX_GAIN_LO) || s_axi_rdata[7:0] == 8'h00);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_cfg_rd;
    $rose(s_axi_rvalid) && rd_idx == `ACC3_IDX_CFG |-> s_axi_rdata[15:0] ==
      $past({chan3_phase_delay, 3'b000, chan3_dc_filter_off, chan3_input_select});
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read mismatch");
  property p_gain_rd;
    $rose(s_axi_rvalid) && rd_idx == `ACC3_IDX_GAIN_UP |-> s_axi_rdata[15:0]
      == $past(chan3_gain_value[23:8]);
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain upper mismatch");
  property p_ofs_rd;
    $rose(s_axi_rvalid) && rd_idx == `ACC3_IDX_OFS_LO |-> s_axi_rdata[15:8]
      == $past(chan3_offset_value[7:0]);
  endproperty
  a_ofs_rd: assert property (p_ofs_rd) else $error("offset lower mismatch");
endmodule // acc3_props
bind acc3_top acc3_props u_props (.*);

//--- verif/acc3_top_bench.sv
`timescale 1ns/1ps
`include "acc3_regs.vh"
module acc3_top_bench;
  localparam [7:0] A_CF = {`ACC3_IDX_CFG, 2'b00};
  localparam [7:0] A_OU = {`ACC3_IDX_OFS_UP, 2'b00};
  localparam [7:0] A_OL = {`ACC3_IDX_OFS_LO, 2'b00};
  localparam [7:0] A_GU = {`ACC3_IDX_GAIN_UP, 2'b00};
  localparam [7:0] A_GL = {`ACC3_IDX_GAIN_LO, 2'b00};
  localparam [1:0] OK = `ACC3_RESP_OKAY;
  localparam [1:0] ER = `ACC3_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic        arv = 1'b0, rry = 1'b0, gdc = 1'b0, smv = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0]  ws = 4'h0;
  logic [23:0] smd = 24'h00_0000;
  wire         awr, wr_y, bv, arr, rv, off, act, resv;
  wire [1:0]   br, rr, sel;
  wire [31:0]  rd;
  wire [9:0]   ph;
  wire [23:0]  ofs, gn, resd;
  int          err_count = 0, num_checks = 0, cyc = 0;
  acc3_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_y),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .global_dc_filter_setting(gdc), .sample_valid(smv), .sample_data(smd),
    .chan3_phase_delay(ph), .chan3_dc_filter_off(off), .chan3_dc_filter_active(act),
    .chan3_input_select(sel), .chan3_offset_value(ofs), .chan3_gain_value(gn),
    .result_valid(resv), .result_data(resd)
  );
  always #12.5 aclk = ~aclk;
  task wrap_up;
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the couple of hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // handshakes judged at negedge, where sampled values are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_hs, w_hs, done;
    @(posedge aclk);
    awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      aw_hs = awv && awr;
      w_hs = wv && wr_y;
      done = bv && bry;
      if (done) chk("bresp", er, br);
      @(posedge aclk);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      if (done) bry <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_hs, done;
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ar_hs = arv && arr;
      done = rv && rry;
      if (done) chk("rdata", e, rd);
      if (done) chk("rresp", er, rr);
      @(posedge aclk);
      if (ar_hs) arv <= 1'b0;
      if (done) rry <= 1'b0;
    end
  endtask
  function automatic logic [23:0] corr(input logic [23:0] s, o, g);
    longint p;
    p = (longint'($signed(s)) - longint'($signed(o))) * longint'(g);
    p = p >>> 23;
    if (p > 64'sh7f_ffff) return 24'h7f_ffff;
    if (p < -64'sh80_0000) return 24'h80_0000;
    return p[23:0];
  endfunction
  task s_reset;
    rd_chk(A_CF, 32'h0000_0000, OK);
    rd_chk(A_OU, 32'h0000_0000, OK);
    rd_chk(A_OL, 32'h0000_0000, OK);
    rd_chk(A_GU, 32'h0000_8000, OK);
    rd_chk(A_GL, 32'h0000_0000, OK);
    @(negedge aclk);
    chk("gain", 24'h80_0000, gn);
  endtask
  task s_cfg;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {10'h200, 3'b111, i[0], i[1:0]};
      wr(A_CF, {16'hffff, v}, 4'hf, OK);
      rd_chk(A_CF, {16'h0000, v & 16'hffc7}, OK);
      @(negedge aclk);
      chk("sel", i[1:0], sel);
      chk("phase", 10'h200, ph);
      chk("off", i[0], off);
    end
    // low lane only: phase top bits must survive
    wr(A_CF, 32'h0000_0000, 4'h1, OK);
    rd_chk(A_CF, 32'h0000_8000, OK);
  endtask
  task s_dc;
    for (int k = 0; k < 4; k++) begin
      wr(A_CF, {29'h0, k[1], 2'b00}, 4'hf, OK);
      @(posedge aclk);
      gdc <= k[0];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("dc_active", k[0] && !k[1], act);
    end
  endtask
  task s_bad;
    wr(8'h74, 32'h0000_ffff, 4'hf, ER);
    rd_chk(8'h74, 32'h0000_0000, ER);
    rd_chk(8'h5c, 32'h0000_0000, ER);
    rd_chk(A_CF, 32'h0000_0004, OK);
  endtask
  task s_cal;
    logic [23:0] tv [5];
    tv = '{24'h00_0064, 24'h7f_ffff, 24'h80_0000, 24'hff_ffed, 24'h00_0000};
    wr(A_OU, 32'h0000_ffff, 4'hf, OK);
    wr(A_OL, 32'h0000_f0ff, 4'hf, OK);
    wr(A_GU, 32'h0000_c000, 4'hf, OK);
    wr(A_GL, 32'h0000_01ff, 4'hf, OK);
    rd_chk(A_OL, 32'h0000_f000, OK);
    rd_chk(A_GL, 32'h0000_0100, OK);
    rd_chk(A_GU, 32'h0000_c000, OK);
    rd_chk(A_OU, 32'h0000_ffff, OK);
    @(negedge aclk);
    chk("offset", 24'hff_fff0, ofs);
    chk("gain", 24'hc0_0001, gn);
    // both saturation ends and a negative fraction
    for (int j = 0; j < 5; j++) begin
      @(posedge aclk);
      smv <= 1'b1;
      smd <= tv[j];
      @(posedge aclk);
      smv <= 1'b0;
      // result_valid stands for the one cycle after the second edge only
      @(posedge aclk);
      @(negedge aclk);
      chk("res_valid", 1'b1, resv);
      chk("result", corr(tv[j], 24'hff_fff0, 24'hc0_0001), resd);
    end
  endtask
  // mid-run reset must bring back every reset value, gain to exactly one
  task s_rerst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_GU, 32'h0000_8000, OK);
    rd_chk(A_GL, 32'h0000_0000, OK);
    rd_chk(A_OU, 32'h0000_0000, OK);
    rd_chk(A_OL, 32'h0000_0000, OK);
    rd_chk(A_CF, 32'h0000_0000, OK);
    @(negedge aclk);
    chk("offset", 24'h00_0000, ofs);
    chk("gain", 24'h80_0000, gn);
    chk("phase", 10'h000, ph);
    chk("off", 1'b0, off);
    chk("dc_active", 1'b1, act);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset;
    s_cfg;
    s_dc;
    s_bad;
    s_cal;
    s_rerst;
    wrap_up;
  end
endmodule // acc3_top_bench
